/* shared/aircs_defines.vh */
// Purpose: constants for the converter source, reference and clock select block
// Assumes: 8-bit register port, one aligned word per register
// Notes: offsets are byte addresses on the plain register port
`ifndef AIRCS_DEFINES_VH
`define AIRCS_DEFINES_VH
`define AIRCS_ADDR_W 4
`define AIRCS_OFS_SEL0 4'h0
`define AIRCS_OFS_CTRL1 4'h4
`define AIRCS_OFS_PINFN 4'h8
`define AIRCS_OFS_PINCFG 4'hc
`define AIRCS_OFS_STAT 4'h1
`define AIRCS_CTRL1_RST 8'h00
`define AIRCS_SEL0_RST 4'h0
`define AIRCS_CH_LSB 0
`define AIRCS_CH_MSB 3
`define AIRCS_CLK_LSB 0
`define AIRCS_CLK_MSB 2
`define AIRCS_REF_LSB 3
`define AIRCS_REF_MSB 4
`define AIRCS_SRC_LSB 5
`define AIRCS_SRC_MSB 7
`define AIRCS_REF_INT 2'h1
`define AIRCS_SRC_AMP2 3'h1
`define AIRCS_SRC_FILT 3'h2
`define AIRCS_SRC_AMP1 3'h3
`define AIRCS_SRC_BATD 3'h4
`define AIRCS_DIV_W 7
`endif

/* rtl/aircs_clk_div.v */
// Purpose: power-of-two divider making a one-cycle conversion clock enable
// Assumes: sel may change at any time; it is sampled into sel_r only at period ends
// Notes: code n gives one pulse every 2**n system clocks
`include "aircs_defines.vh"
module aircs_clk_div (
    // clock and reset
    input wire mclk_i,
    input wire srst_i,
    // control
    input wire [2:0] sel_i,
    // enable out
    output reg tick_o
);
    reg [`AIRCS_DIV_W-1:0] cnt_r;
    reg [2:0] sel_r;
    wire [`AIRCS_DIV_W-1:0] last_w = (7'h01 << sel_r) - 7'h01;
    wire wrap_w = (cnt_r >= last_w);

    // new code is taken only at a period end, so no short or runt pulse appears
    always @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            cnt_r <= 7'h00;
            sel_r <= 3'h0;
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= wrap_w; // [R6] [R12]
            if (wrap_w)
            begin
                cnt_r <= 7'h00;
                sel_r <= sel_i; // [R12]
            end
            else
                cnt_r <= cnt_r + 7'h01;
        end
    end
endmodule // aircs_clk_div

/* rtl/aircs_pin_ctl.v */
// Purpose: per-pin override when a pin is given to the converter
// Assumes: four pins, each with a two-bit function code
// Notes: function code 2'h3 marks the analog input function
`include "aircs_defines.vh"
module aircs_pin_ctl (
    // clock and reset
    input wire mclk_i,
    input wire srst_i,
    // pin configuration
    input wire [3:0] fn_lo_i,
    input wire [3:0] fn_hi_i,
    input wire [3:0] pull_en_i,
    input wire [3:0] dir_in_i,
    // resolved controls
    output reg [3:0] analog_o,
    output reg [3:0] pull_o,
    output reg [3:0] dir_in_o,
    output reg [3:0] dig_en_o
);
    wire [3:0] an_w = fn_lo_i & fn_hi_i;

    always @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            analog_o <= 4'h0;
            pull_o <= 4'h0;
            dir_in_o <= 4'hf;
            dig_en_o <= 4'h0;
        end
        else
        begin
            analog_o <= an_w;
            dig_en_o <= ~an_w; // [R7]
            pull_o <= pull_en_i & ~an_w; // [R8]
            dir_in_o <= dir_in_i | an_w; // [R9]
        end
    end
endmodule // aircs_pin_ctl

/* rtl/aircs_top.v */
// Purpose: converter input, reference and conversion clock selection
// Assumes: registers on a plain port, read data one cycle after the strobe
// Notes: analog switches are driven as one-hot enables
//
// Notes on behaviour
// R1: channel codes 0000 to 0011 connect analog pins 0 to 3.
// R2: channel codes 0100 to 1111 connect no pin; external path floats.
// R3: source codes 001 to 100 pick amp2, filter, amp1, battery voltage.
// R4: source codes 000 and 101 to 111 take the external pin path.
// R5: reference code 01 picks the regulator; all other codes the reference pin.
// R6: clock code n divides the system clock by two to the n.
// R7: a pin given to the converter loses all other functions.
// R8: a pin given to the converter drops its pull-high resistor.
// R9: converter function overrides the pin direction setting.
// R10: software sets channel 0100 to 1111 whenever an internal source is used.
// R11: software keeps the reference pin function off while regulator is reference.
// R12: divided clock drives conversion; selector change never corrupts it.
//
// The address map and the strobed register port are this design's own decisions.
`include "aircs_defines.vh"
module aircs_top (
    // clock and reset
    input wire mclk_i,
    input wire srst_i,
    // register port
    input wire [`AIRCS_ADDR_W-1:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // pin configuration inputs from the port logic
    input wire [3:0] pull_en_i,
    input wire [3:0] dir_in_i,
    // analog switch enables and conversion clock enable
    output reg [3:0] pin_sw_o,
    output reg [3:0] int_sw_o,
    output reg ref_int_o,
    output reg ref_pin_o,
    output reg conv_tick_o,
    // pin overrides
    output wire [3:0] pin_analog_o,
    output wire [3:0] pin_pull_o,
    output wire [3:0] pin_dir_in_o,
    output wire [3:0] pin_dig_en_o
);
    reg [3:0] ext_channel_sel_r;
    reg [7:0] ctrl1_r;
    reg [3:0] pin_function_sel_lo_r;
    reg [3:0] pin_function_sel_hi_r;
    reg ref_pin_fn_r;
    wire div_tick_w;

    wire [2:0] input_source_sel = ctrl1_r[`AIRCS_SRC_MSB:`AIRCS_SRC_LSB];
    wire [1:0] ref_source_sel = ctrl1_r[`AIRCS_REF_MSB:`AIRCS_REF_LSB];
    wire [2:0] conv_clk_div_sel = ctrl1_r[`AIRCS_CLK_MSB:`AIRCS_CLK_LSB];

    // one-hot decode of a two-bit pin index when the code is in range
    function [3:0] pin_dec;
        input [3:0] code;
        begin
            pin_dec = 4'h0;
            if (code[3:2] == 2'h0)
                pin_dec = 4'h1 << code[1:0]; // [R1] [R2]
        end
    endfunction

    function is_internal;
        input [2:0] src;
        begin
            is_internal = (src >= `AIRCS_SRC_AMP2) && (src <= `AIRCS_SRC_BATD);
        end
    endfunction

    // register writes
    always @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            ext_channel_sel_r <= `AIRCS_SEL0_RST;
            ctrl1_r <= `AIRCS_CTRL1_RST;
            pin_function_sel_lo_r <= 4'h0;
            pin_function_sel_hi_r <= 4'h0;
            ref_pin_fn_r <= 1'b0;
        end
        else if (wr_i)
        begin
            case (addr_i)
                `AIRCS_OFS_SEL0: ext_channel_sel_r <= wdata_i[`AIRCS_CH_MSB:`AIRCS_CH_LSB];
                `AIRCS_OFS_CTRL1: ctrl1_r <= wdata_i;
                `AIRCS_OFS_PINFN:
                begin
                    pin_function_sel_lo_r <= wdata_i[3:0];
                    pin_function_sel_hi_r <= wdata_i[7:4];
                end
                `AIRCS_OFS_PINCFG: ref_pin_fn_r <= wdata_i[0];
                default: ;
            endcase
        end
    end

    // reads; unmapped addresses return zero
    always @(posedge mclk_i)
    begin
        if (srst_i)
            rdata_o <= 8'h00;
        else if (rd_i)
        begin
            case (addr_i)
                `AIRCS_OFS_SEL0: rdata_o <= {4'h0, ext_channel_sel_r};
                `AIRCS_OFS_CTRL1: rdata_o <= ctrl1_r;
                `AIRCS_OFS_PINFN: rdata_o <= {pin_function_sel_hi_r, pin_function_sel_lo_r};
                `AIRCS_OFS_PINCFG: rdata_o <= {7'h00, ref_pin_fn_r};
                `AIRCS_OFS_STAT: rdata_o <= {pin_sw_o, int_sw_o};
                default: rdata_o <= 8'h00;
            endcase
        end
        else
            rdata_o <= 8'h00;
    end

    // analog switch control; external path is gated by pin function only, not by source select
    always @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            pin_sw_o <= 4'h0;
            int_sw_o <= 4'h0;
            ref_int_o <= 1'b0;
            ref_pin_o <= 1'b0;
            conv_tick_o <= 1'b0;
        end
        else
        begin
            // the channel selector is not masked on internal sources, so a bad
            // setting still shorts the pin as the hardware would; software avoids it
            if (is_internal(input_source_sel))
                int_sw_o <= 4'h1 << (input_source_sel - `AIRCS_SRC_AMP2); // [R3] [R10]
            else
                int_sw_o <= 4'h0; // [R4]
            pin_sw_o <= pin_dec(ext_channel_sel_r) & pin_analog_o; // [R1] [R2] [R4]
            ref_int_o <= (ref_source_sel == `AIRCS_REF_INT); // [R5] [R11]
            ref_pin_o <= (ref_source_sel != `AIRCS_REF_INT) & ref_pin_fn_r; // [R5]
            conv_tick_o <= div_tick_w; // [R12]
        end
    end

    aircs_clk_div u_div (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .sel_i(conv_clk_div_sel),
        .tick_o(div_tick_w)
    );

    aircs_pin_ctl u_pin (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .fn_lo_i(pin_function_sel_lo_r),
        .fn_hi_i(pin_function_sel_hi_r),
        .pull_en_i(pull_en_i),
        .dir_in_i(dir_in_i),
        .analog_o(pin_analog_o),
        .pull_o(pin_pull_o),
        .dir_in_o(pin_dir_in_o),
        .dig_en_o(pin_dig_en_o)
    );
endmodule // aircs_top

/* sim/aircs_top_assertions.sv */
// Purpose: port checks for aircs_top
// Assumes: one clock, synchronous reset
// Notes: divider rate is left to the bench
module aircs_top_chk (
    input wire mclk_i,
    input wire srst_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire [3:0] pin_sw_o,
    input wire [3:0] int_sw_o,
    input wire ref_int_o,
    input wire ref_pin_o,
    input wire [3:0] pin_analog_o,
    input wire [3:0] pin_pull_o,
    input wire [3:0] pin_dir_in_o,
    input wire [3:0] pin_dig_en_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    chk_pin_one_hot: assert property ($onehot0(pin_sw_o)) else $error("pin overlap");
    chk_sw_needs_an: assert property ((pin_sw_o & ~$past(pin_analog_o)) == 4'h0) else $error("pin not analog");
    chk_int_one_hot: assert property ($onehot0(int_sw_o)) else $error("source overlap");
    chk_ref_excl: assert property (!(ref_int_o && ref_pin_o)) else $error("both refs");
    chk_pull_drop: assert property ((pin_pull_o & pin_analog_o) == 4'h0) else $error("pull kept");
    chk_dig_drop: assert property ((pin_dig_en_o & pin_analog_o) == 4'h0) else $error("digital kept");
    chk_dir_over: assert property ((pin_analog_o & ~pin_dir_in_o) == 4'h0) else $error("dir not input");
    chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("stray rdata");
endmodule // aircs_top_chk

bind aircs_top aircs_top_chk u_chk (
    .mclk_i(mclk_i), .srst_i(srst_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_sw_o(pin_sw_o), .int_sw_o(int_sw_o), .ref_int_o(ref_int_o), .ref_pin_o(ref_pin_o),
    .pin_analog_o(pin_analog_o), .pin_pull_o(pin_pull_o), .pin_dir_in_o(pin_dir_in_o),
    .pin_dig_en_o(pin_dig_en_o)
);

/* sim/aircs_analog_model.sv */
// Purpose: far side: pins, internal sources, reference pin
// Assumes: switch enables high connect
// Notes: flags any short between a pin and an internal node
module aircs_analog_model (
    input wire [3:0] pin_sw_i,
    input wire [3:0] int_sw_i,
    input wire ref_int_i,
    input wire ref_pin_i,
    output wire short_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign short_o = (|pin_sw_i && |int_sw_i) || (ref_int_i && ref_pin_i);
endmodule // aircs_analog_model

/* sim/test_adc_input_ref_clock_select.sv */
// Purpose: bench for aircs_top
// Assumes: register offsets from aircs_defines.vh
// Notes: stimulus keeps pins off internal nodes
`include "aircs_defines.vh"
module test_adc_input_ref_clock_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, ref_int_o, ref_pin_o, conv_tick_o, short_w;
    logic [3:0] addr_i = 0, pull_en_i = 0, dir_in_i = 0, pin_sw_o, int_sw_o, a;
    logic [3:0] pin_analog_o, pin_pull_o, pin_dir_in_o, pin_dig_en_o;
    logic [7:0] wdata_i = 0, rdata_o, d;
    int n_mismatch = 0, comparisons = 0, seed = 14, n, i;
    aircs_top u_dut (.mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .pull_en_i(pull_en_i), .dir_in_i(dir_in_i), .pin_sw_o(pin_sw_o),
        .int_sw_o(int_sw_o), .ref_int_o(ref_int_o), .ref_pin_o(ref_pin_o), .conv_tick_o(conv_tick_o),
        .pin_analog_o(pin_analog_o), .pin_pull_o(pin_pull_o), .pin_dir_in_o(pin_dir_in_o),
        .pin_dig_en_o(pin_dig_en_o));
    aircs_analog_model u_far (.pin_sw_i(pin_sw_o), .int_sw_i(int_sw_o), .ref_int_i(ref_int_o),
        .ref_pin_i(ref_pin_o), .short_o(short_w));
    initial forever #2.5 mclk_i = ~mclk_i;
    function automatic logic [3:0] hot(input int c, input int lo);
        return (c >= lo && c < lo + 4) ? 4'(1 << (c - lo)) : 4'h0;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [7:0] v);
        @(posedge mclk_i);
        addr_i <= ad;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask
    task automatic rd(input logic [3:0] ad);
        @(posedge mclk_i);
        addr_i <= ad;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end
    initial
    begin
        repeat (3) @(posedge mclk_i);
        srst_i <= 1'b0;
        rd(`AIRCS_OFS_CTRL1);
        chk(d, `AIRCS_CTRL1_RST);
        wr(`AIRCS_OFS_PINFN, 8'hff);
        for (i = 0; i < 16; i++)
        begin
            wr(`AIRCS_OFS_SEL0, 8'(i));
            chk(pin_sw_o, hot(i, 0));
        end
        for (i = 0; i < 8; i++)
        begin
            wr(`AIRCS_OFS_CTRL1, 8'(i << 5));
            chk(int_sw_o, hot(i, 1));
        end
        for (i = 0; i < 4; i++)
        begin
            wr(`AIRCS_OFS_PINCFG, 8'h00);
            wr(`AIRCS_OFS_CTRL1, 8'(i << 3));
            wr(`AIRCS_OFS_PINCFG, 8'(i != 1));
            chk({ref_int_o, ref_pin_o}, {i == 1, i != 1});
        end
        for (i = 0; i < 8; i++)
        begin
            wr(`AIRCS_OFS_CTRL1, 8'(i));
            repeat (300) @(posedge mclk_i);
            n = 0;
            repeat (512)
            begin
                @(posedge mclk_i);
                #1;
                n += conv_tick_o;
            end
            chk(8'(n >> 1), 8'(256 >> i));
        end
        for (i = 0; i < 24; i++)
        begin
            @(posedge mclk_i);
            pull_en_i <= 4'($random(seed));
            dir_in_i <= 4'($random(seed));
            wr(`AIRCS_OFS_PINFN, 8'($random(seed)));
            a = wdata_i[3:0] & wdata_i[7:4];
            chk(pin_analog_o, a);
            chk(pin_dig_en_o, 4'(~a));
            chk(pin_pull_o, pull_en_i & ~a);
            chk(pin_dir_in_o, dir_in_i | a);
            wr(`AIRCS_OFS_CTRL1, 8'($random(seed)) & 8'he7);
            rd(`AIRCS_OFS_CTRL1);
            chk(d, wdata_i);
            rd(`AIRCS_OFS_STAT);
            chk(d, {4'h0, hot(wdata_i[7:5], 1)});
            chk(short_w, 1'b0);
        end
        rd(4'h2);
        chk(d, 8'h00);
        tally_and_finish();
    end
endmodule // test_adc_input_ref_clock_select
